/* hw/operand_address_regs.vh */
// constants for the operand address generator
`ifndef OPERAND_ADDRESS_REGS_VH
`define OPERAND_ADDRESS_REGS_VH

// addressing mode codes, three bits
`define MODE_INHERENT   3'h0
`define MODE_IMMEDIATE  3'h1
`define MODE_DIRECT     3'h2
`define MODE_EXTENDED   3'h3
`define MODE_INDEXED    3'h4
`define MODE_INDEXED_8  3'h5
`define MODE_INDEXED_16 3'h6
`define MODE_RELATIVE   3'h7

// instruction lengths in bytes
`define LEN_ONE   2'h1
`define LEN_TWO   2'h2
`define LEN_THREE 2'h3

// opcode classes by upper nibble
`define CLASS_BIT_BRANCH 4'h0
`define CLASS_BIT_MANIP  4'h1
`define CLASS_BRANCH     4'h2
`define CLASS_RMW_DIR    4'h3
`define CLASS_RMW_INH_A  4'h4
`define CLASS_RMW_INH_X  4'h5
`define CLASS_RMW_IX1    4'h6
`define CLASS_RMW_IX     4'h7
`define CLASS_CTRL_A     4'h8
`define CLASS_CTRL_B     4'h9
`define CLASS_IMM        4'hA
`define CLASS_DIR        4'hB
`define CLASS_EXT        4'hC
`define CLASS_IX2        4'hD
`define CLASS_IX1        4'hE
`define CLASS_IX         4'hF

// lowest page high byte
`define PAGE_ZERO_HIGH 8'h00

`endif

/* hw/operand_mode_decode.v */
// opcode to addressing mode and length lookup
`timescale 1ns/100ps
`include "operand_address_regs.vh"

module operand_mode_decode (
  input  wire [7:0] opcode,
  output reg  [2:0] mode,
  output reg  [1:0] length,
  output reg        bit_branch
);

  // classify by upper nibble; every class lands on one of eight modes
  always @* begin
    mode       = `MODE_INHERENT;
    length     = `LEN_ONE;
    bit_branch = 1'b0;
    case (opcode[7:4])
      `CLASS_BIT_BRANCH: begin
        mode       = `MODE_DIRECT;
        length     = `LEN_THREE;
        bit_branch = 1'b1;
      end
      `CLASS_BIT_MANIP, `CLASS_RMW_DIR, `CLASS_DIR: begin
        mode   = `MODE_DIRECT;
        length = `LEN_TWO;
      end
      `CLASS_BRANCH: begin
        mode   = `MODE_RELATIVE;
        length = `LEN_TWO;
      end
      `CLASS_RMW_INH_A, `CLASS_RMW_INH_X, `CLASS_CTRL_A, `CLASS_CTRL_B: begin
        mode   = `MODE_INHERENT;
        length = `LEN_ONE;
      end
      `CLASS_RMW_IX1, `CLASS_IX1: begin
        mode   = `MODE_INDEXED_8;
        length = `LEN_TWO;
      end
      `CLASS_RMW_IX, `CLASS_IX: begin
        mode   = `MODE_INDEXED;
        length = `LEN_ONE;
      end
      `CLASS_IMM: begin
        mode   = `MODE_IMMEDIATE;
        length = `LEN_TWO;
      end
      `CLASS_EXT: begin
        mode   = `MODE_EXTENDED;
        length = `LEN_THREE;
      end
      `CLASS_IX2: begin
        mode   = `MODE_INDEXED_16;
        length = `LEN_THREE;
      end
      default: begin
        mode   = `MODE_INHERENT;
        length = `LEN_ONE;
      end
    endcase
  end

endmodule

/* hw/cpu_operand_address_generator.v */
// operand address and branch target generation for the cpu
`timescale 1ns/100ps
`include "operand_address_regs.vh"

module cpu_operand_address_generator (
  input  wire        clock,
  input  wire        rst,
  input  wire        start,
  input  wire [7:0]  opcode,
  input  wire [7:0]  first_byte,
  input  wire [7:0]  second_byte,
  input  wire [7:0]  index_value,
  input  wire [15:0] opcode_pc,
  input  wire        branch_condition,
  output wire        ready,
  output reg         done,
  output reg  [2:0]  mode,
  output reg  [1:0]  length,
  output reg         address_valid,
  output reg  [15:0] operand_address,
  output reg         immediate_valid,
  output reg  [7:0]  immediate_data,
  output reg         is_branch,
  output reg         branch_when_bit_one,
  output reg         branch_when_bit_zero,
  output reg         tested_bit,
  output reg         branch_taken,
  output reg  [15:0] branch_target,
  output reg  [15:0] sequential_pc,
  output reg  [15:0] new_pc
);

  // pipeline state machine codes
  localparam [1:0] st_idle    = 2'h0;
  localparam [1:0] st_compute = 2'h1;
  localparam [1:0] st_answer  = 2'h2;

  reg  [1:0]  state;
  reg  [1:0]  next_state;

  // captured request
  reg  [7:0]  cap_opcode;
  reg  [7:0]  cap_first;
  reg  [7:0]  cap_second;
  reg  [7:0]  cap_index;
  reg  [15:0] cap_pc;
  reg         cap_condition;

  // decoder results
  wire [2:0]  dec_mode;
  wire [1:0]  dec_length;
  wire        dec_bit_branch;

  // combinational address work
  reg  [15:0] next_operand_address;
  reg         next_address_valid;
  reg         next_immediate_valid;
  reg  [7:0]  next_immediate_data;
  reg         next_is_branch;
  reg  [7:0]  displacement;
  reg  [15:0] next_sequential_pc;
  reg  [15:0] next_branch_target;
  reg         next_branch_taken;
  reg  [15:0] next_new_pc;
  reg         next_tested_bit;

  wire [15:0] sext_displacement;
  wire [8:0]  ix1_sum;
  wire [15:0] ix2_offset;
  wire [15:0] ix2_sum;
  wire [15:0] ext_address;
  wire [15:0] page_zero_first;
  wire [15:0] page_zero_index;

  // one request in flight; the fetch unit must wait while busy
  assign ready = (state == st_idle);

  // state register
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= st_idle;
    end else begin
      state <= next_state;
    end
  end

  // request walks idle, compute, answer and back
  always @* begin
    next_state = state;
    case (state)
      st_idle: begin
        if (start) begin
          next_state = st_compute;
        end
      end
      st_compute: begin
        next_state = st_answer;
      end
      st_answer: begin
        next_state = st_idle;
      end
      default: begin
        next_state = st_idle;
      end
    endcase
  end

  // capture the instruction bytes so later fetch traffic cannot disturb them
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      cap_opcode <= 8'h00;
      cap_first  <= 8'h00;
      cap_second <= 8'h00;
    end else if (start && ready) begin
      cap_opcode <= opcode;
      cap_first  <= first_byte;
      cap_second <= second_byte;
    end
  end

  // cpu context travels with the bytes of the same request
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      cap_index     <= 8'h00;
      cap_pc        <= 16'h0000;
      cap_condition <= 1'b0;
    end else if (start && ready) begin
      cap_index     <= index_value;
      cap_pc        <= opcode_pc;
      cap_condition <= branch_condition;
    end
  end

  operand_mode_decode u_decode (
    .opcode     (cap_opcode),
    .mode       (dec_mode),
    .length     (dec_length),
    .bit_branch (dec_bit_branch)
  );

  // candidate addresses, sixteen bits wide except the nine-bit ix1_sum
  assign page_zero_first = {`PAGE_ZERO_HIGH, cap_first};
  assign page_zero_index = {`PAGE_ZERO_HIGH, cap_index};
  assign ext_address     = {cap_first, cap_second};
  // nine-bit sum keeps the carry so $01FE is reachable
  assign ix1_sum         = {1'b0, cap_index} + {1'b0, cap_first};
  assign ix2_offset      = {cap_first, cap_second};
  // wraps at the top of memory like the cpu address bus
  assign ix2_sum         = ix2_offset + {8'h00, cap_index};

  // branch displacement sits after the direct address for bit branches
  always @* begin
    if (dec_bit_branch) begin
      displacement = cap_second;
    end else begin
      displacement = cap_first;
    end
  end

  // two's complement sign extension, low byte passes straight through
  assign sext_displacement[7:0] = displacement;

  // each upper bit copies the sign, so backward branches reach -128
  genvar sx;
  generate
    for (sx = 8; sx < 16; sx = sx + 1) begin : sign_copy
      assign sext_displacement[sx] = displacement[7];
    end
  endgenerate

  // operand address and immediate data per mode
  always @* begin
    next_operand_address = 16'h0000;
    next_address_valid   = 1'b0;
    next_immediate_valid = 1'b0;
    next_immediate_data  = 8'h00;
    next_is_branch       = 1'b0;
    case (dec_mode)
      `MODE_INHERENT: begin
        next_address_valid = 1'b0;
      end
      `MODE_IMMEDIATE: begin
        next_immediate_valid = 1'b1;
        next_immediate_data  = cap_first;
      end
      `MODE_DIRECT: begin
        next_operand_address = page_zero_first;
        next_address_valid   = 1'b1;
        next_is_branch       = dec_bit_branch;
      end
      `MODE_EXTENDED: begin
        next_operand_address = ext_address;
        next_address_valid   = 1'b1;
      end
      `MODE_INDEXED: begin
        next_operand_address = page_zero_index;
        next_address_valid   = 1'b1;
      end
      `MODE_INDEXED_8: begin
        next_operand_address = {7'h00, ix1_sum};
        next_address_valid   = 1'b1;
      end
      `MODE_INDEXED_16: begin
        next_operand_address = ix2_sum;
        next_address_valid   = 1'b1;
      end
      `MODE_RELATIVE: begin
        next_is_branch = 1'b1;
      end
      default: begin
        next_address_valid = 1'b0;
      end
    endcase
  end

  // pc moves past the whole instruction before displacement is added
  always @* begin
    next_sequential_pc = cap_pc + {14'h0000, dec_length};
    next_branch_target = next_sequential_pc + sext_displacement;
  end

  // only a branch with its condition true leaves the straight line
  always @* begin
    next_branch_taken = next_is_branch & cap_condition;
    if (next_branch_taken) begin
      next_new_pc = next_branch_target;
    end else begin
      next_new_pc = next_sequential_pc;
    end
  end

  // tested bit of a bit branch is the captured branch_condition, zero for other opcodes
  always @* begin
    next_tested_bit = 1'b0;
    if (dec_bit_branch) begin
      next_tested_bit = cap_condition;
    end
  end

  // answer registers load in the compute state, hold afterwards
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      mode            <= `MODE_INHERENT;
      length          <= `LEN_ONE;
      address_valid   <= 1'b0;
      operand_address <= 16'h0000;
      immediate_valid <= 1'b0;
      immediate_data  <= 8'h00;
    end else if (state == st_compute) begin
      mode            <= dec_mode;
      length          <= dec_length;
      address_valid   <= next_address_valid;
      operand_address <= next_operand_address;
      immediate_valid <= next_immediate_valid;
      immediate_data  <= next_immediate_data;
    end
  end

  // branch kind and decision, loaded on the same compute edge
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      is_branch            <= 1'b0;
      branch_when_bit_one  <= 1'b0;
      branch_when_bit_zero <= 1'b0;
      tested_bit           <= 1'b0;
      branch_taken         <= 1'b0;
    end else if (state == st_compute) begin
      is_branch            <= next_is_branch;
      // even opcodes branch on a one, odd ones on a zero
      branch_when_bit_one  <= dec_bit_branch & ~cap_opcode[0];
      branch_when_bit_zero <= dec_bit_branch & cap_opcode[0];
      tested_bit           <= next_tested_bit;
      branch_taken         <= next_branch_taken;
    end
  end

  // target is kept even when not taken, so the fetch unit may prefetch it
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      branch_target <= 16'h0000;
    end else if (state == st_compute) begin
      branch_target <= next_branch_target;
    end
  end

  // fall-through and chosen pc for the fetch unit
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      sequential_pc <= 16'h0000;
      new_pc        <= 16'h0000;
    end else if (state == st_compute) begin
      sequential_pc <= next_sequential_pc;
      new_pc        <= next_new_pc;
    end
  end

  // done pulses one cycle, together with fresh answer registers
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      done <= 1'b0;
    end else begin
      done <= (state == st_compute);
    end
  end

endmodule

/* test/operand_address_monitor.sv */
// assertion checker bound to the operand address generator
`timescale 1ns/100ps
`include "operand_address_regs.vh"

module operand_address_monitor (
  input wire        clock,
  input wire        rst,
  input wire        start,
  input wire [7:0]  first_byte,
  input wire [7:0]  second_byte,
  input wire [7:0]  index_value,
  input wire [15:0] opcode_pc,
  input wire        branch_condition,
  input wire        ready,
  input wire        done,
  input wire [2:0]  mode,
  input wire [1:0]  length,
  input wire        address_valid,
  input wire [15:0] operand_address,
  input wire        immediate_valid,
  input wire        is_branch,
  input wire        branch_taken,
  input wire [15:0] branch_target,
  input wire [15:0] sequential_pc,
  input wire [15:0] new_pc
);
  reg [7:0]  b1;
  reg [7:0]  b2;
  reg [7:0]  x;
  reg [15:0] pc;
  reg        cnd;
  wire [7:0] d = (length == 2'h3) ? b2 : b1;

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  // request copy, so answers are judged against what was taken
  always @(posedge clock) begin
    if (start && ready) begin
      b1 <= first_byte;
      b2 <= second_byte;
      x <= index_value;
      pc <= opcode_pc;
      cnd <= branch_condition;
    end
  end

  chk_answer_timing: assert property (start && ready |=> !ready && !done ##1 done)
    else $error("answer not two cycles after request");
  chk_inherent_noaddr: assert property (done && mode == `MODE_INHERENT |->
    !address_valid && length == 2'h1) else $error("inherent form wrong");
  chk_immediate_form: assert property (done && mode == `MODE_IMMEDIATE |->
    immediate_valid && !address_valid && length == 2'h2) else $error("immediate form wrong");
  chk_direct_addr: assert property (done && mode == `MODE_DIRECT |->
    operand_address == {8'h00, b1}) else $error("direct address wrong");
  chk_extended_addr: assert property (done && mode == `MODE_EXTENDED |->
    operand_address == {b1, b2} && length == 2'h3) else $error("extended address wrong");
  chk_index_plain: assert property (done && mode == `MODE_INDEXED |->
    operand_address == {8'h00, x} && length == 2'h1) else $error("indexed address wrong");
  chk_index_byte: assert property (done && mode == `MODE_INDEXED_8 |->
    operand_address == {8'h00, x} + {8'h00, b1}) else $error("indexed 8 address wrong");
  chk_index_word: assert property (done && mode == `MODE_INDEXED_16 |->
    operand_address == {b1, b2} + {8'h00, x}) else $error("indexed 16 address wrong");
  chk_seq_pc: assert property (done |-> sequential_pc == pc + length)
    else $error("sequential pc wrong");
  chk_branch_target: assert property (done && is_branch |->
    branch_target == sequential_pc + {{8{d[7]}}, d}) else $error("branch target wrong");
  chk_taken_pc: assert property (done |-> branch_taken == (is_branch && cnd) &&
    new_pc == (branch_taken ? branch_target : sequential_pc)) else $error("new pc wrong");

  cov_taken: cover property (done && branch_taken);
  cov_word: cover property (done && mode == `MODE_INDEXED_16);
  cov_imm: cover property (done && immediate_valid);
endmodule

bind cpu_operand_address_generator operand_address_monitor u_mon (.*);

/* test/fetch_model.sv */
// fetch unit stand-in that launches a new request whenever go is high and ready returns
`timescale 1ns/100ps

module fetch_model (
  input wire clock,
  input wire rst,
  input wire ready,
  input wire go,
  output reg start
);
  // one pulse per request; waits for ready so nothing is refused
  always @(posedge clock or posedge rst) begin
    if (rst)
      start <= 1'b0;
    else
      start <= go && ready && !start;
  end
endmodule

/* test/tb.sv */
// self-checking bench for the operand address generator
`timescale 1ns/100ps

module tb;
  logic        clock = 0;
  logic        rst = 1;
  logic        go = 0;
  logic [7:0]  opcode = 0, first_byte = 0, second_byte = 0, index_value = 0;
  logic [15:0] opcode_pc = 0;
  logic        branch_condition = 0;
  wire         start, ready, done, address_valid, immediate_valid, is_branch;
  wire         branch_when_bit_one, branch_when_bit_zero, tested_bit, branch_taken;
  wire [2:0]   mode;
  wire [1:0]   length;
  wire [7:0]   immediate_data;
  wire [15:0]  operand_address, branch_target, sequential_pc, new_pc;
  int          fail_count = 0, checked = 0, cycles = 0;
  // expected mode and length by upper nibble of the opcode
  logic [2:0]  em [0:15] = '{3'h2, 3'h2, 3'h7, 3'h2, 3'h0, 3'h0, 3'h5, 3'h4,
                             3'h0, 3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h5, 3'h4};
  logic [1:0]  el [0:15] = '{2'h3, 2'h2, 2'h2, 2'h2, 2'h1, 2'h1, 2'h2, 2'h1,
                             2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3, 2'h2, 2'h1};

  cpu_operand_address_generator u_cpu_operand_address_generator (.*);
  fetch_model u_fetch_model (.clock(clock), .rst(rst), .ready(ready), .go(go), .start(start));

  initial forever #4 clock = ~clock;

  task stop_test;
    $display("mismatches %0d checks %0d", fail_count, checked);
    if (fail_count == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // hang guard, far above the roughly 160 cycles needed
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      stop_test;
    end
  end

  task chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // inputs stay put until done, the answer is read after it
  task issue(input logic [7:0] op, b1, b2, x, input logic [15:0] pc, input logic c);
    int n;
    n = 0;
    @(posedge clock);
    opcode <= op;
    first_byte <= b1;
    second_byte <= b2;
    index_value <= x;
    opcode_pc <= pc;
    branch_condition <= c;
    go <= 1'b1;
    // done is looked at mid-cycle, away from the edge that launches it
    do begin
      @(negedge clock);
      n++;
    end while (done !== 1'b1 && n < 20);
    chk(done, 1'b1);
    @(posedge clock);
    go <= 1'b0;
  endtask

  task t_modes;
    for (int n = 0; n < 16; n++) begin
      issue({n[3:0], 4'h6}, 8'h00, 8'h00, 8'h00, 16'h0000, 1'b0);
      chk(mode, em[n]);
      chk(length, el[n]);
    end
  endtask

  task t_noaddr;
    issue(8'h4C, 8'hAA, 8'hAA, 8'h11, 16'h0200, 1'b1);
    chk(address_valid, 1'b0);
    issue(8'hA6, 8'h55, 8'h00, 8'h11, 16'h0200, 1'b0);
    chk(immediate_data, 8'h55);
    chk(immediate_valid, 1'b1);
    chk(address_valid, 1'b0);
  endtask

  task t_absolute;
    issue(8'hB6, 8'h80, 8'h44, 8'h00, 16'h0300, 1'b0);
    chk(operand_address, 16'h0080);
    issue(8'hC6, 8'h12, 8'h34, 8'h00, 16'h0300, 1'b0);
    chk(operand_address, 16'h1234);
  endtask

  task t_indexed;
    issue(8'hF6, 8'h33, 8'h44, 8'hFF, 16'h0400, 1'b0);
    chk(operand_address, 16'h00FF);
    issue(8'hE6, 8'hFF, 8'h44, 8'hFF, 16'h0400, 1'b0);
    chk(operand_address, 16'h01FE);
    issue(8'hD6, 8'hFF, 8'hFF, 8'h02, 16'h0400, 1'b0);
    chk(operand_address, 16'h0001);
  endtask

  task t_bit_branch;
    issue(8'h00, 8'h12, 8'hFE, 8'h00, 16'h1000, 1'b1);
    chk(operand_address, 16'h0012);
    chk(branch_when_bit_one, 1'b1);
    chk(tested_bit, 1'b1);
    chk(new_pc, 16'h1001);
    issue(8'h01, 8'h12, 8'hFE, 8'h00, 16'h1000, 1'b0);
    chk(branch_when_bit_zero, 1'b1);
    chk(tested_bit, 1'b0);
    chk(new_pc, 16'h1003);
  endtask

  // reset in mid-run clears the answers, first request right after it works
  task t_reset;
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    chk(new_pc, 16'h0000);
    chk(branch_target, 16'h0000);
    chk(length, 2'h1);
    chk(done, 1'b0);
    chk(ready, 1'b1);
    issue(8'hC6, 8'hAB, 8'hCD, 8'h00, 16'h0000, 1'b0);
    chk(operand_address, 16'hABCD);
  endtask

  task t_relative;
    issue(8'h20, 8'h7F, 8'h00, 8'h00, 16'hFFF0, 1'b1);
    chk(new_pc, 16'h0071);
    chk(address_valid, 1'b0);
    issue(8'h20, 8'h80, 8'h00, 8'h00, 16'h0100, 1'b1);
    chk(new_pc, 16'h0082);
    issue(8'h20, 8'h80, 8'h00, 8'h00, 16'h0100, 1'b0);
    chk(new_pc, 16'h0102);
    chk(branch_target, 16'h0082);
  endtask

  initial begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    chk(ready, 1'b1);
    chk(length, 2'h1);
    t_modes;
    t_noaddr;
    t_absolute;
    t_indexed;
    t_bit_branch;
    t_relative;
    t_reset;
    stop_test;
  end
endmodule
